// *** nva_defs.svh ***
`ifndef NVA_DEFS_SVH
`define NVA_DEFS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define NVA_CLK_MHZ 25
`define NVA_EE_WRITE_US 4000
`define NVA_FL_PROG_US 2000

// ****************************************
// Register byte offsets
// ****************************************
`define NVA_REG_CTRL 8'h00
`define NVA_REG_UNLOCK 8'h04
`define NVA_REG_EE_ADDR 8'h08
`define NVA_REG_EE_DATA 8'h0C
`define NVA_REG_TBL_PTR 8'h10
`define NVA_REG_TBL_LATCH 8'h14
`define NVA_REG_TBL_CMD 8'h18
`define NVA_REG_STATUS 8'h1C

// ****************************************
// Control field positions
// ****************************************
`define NVA_CTRL_PGD 7
`define NVA_CTRL_CONFIG_SPACE_SELECT 6
`define NVA_CTRL_FREE 4
`define NVA_CTRL_WRITE_ENABLE_BIT 2
`define NVA_CTRL_WR 1
`define NVA_CTRL_RD 0

// ****************************************
// Table command and status positions
// ****************************************
`define NVA_CMD_READ 0
`define NVA_CMD_WRITE 1
`define NVA_CMD_BULK 2
`define NVA_CMD_INC 3
`define NVA_STAT_DONE 0
`define NVA_STAT_BULK 1
`define NVA_STAT_FL_BUSY 2
`define NVA_STAT_EE_BUSY 3

// ****************************************
// Unlock keys and sizes
// ****************************************
`define NVA_KEY_FIRST 8'h55
`define NVA_KEY_SECOND 8'hAA
`define NVA_FL_BYTES 256
`define NVA_EE_BYTES 256
`define NVA_HOLD_BYTES 32
`define NVA_ERASE_BYTES 64
`define NVA_ERASED 8'hFF

`endif

// *** nva_pkg.sv ***
package nva_pkg;

  typedef enum logic [1:0] {
    NVA_ST_IDLE = 2'b00,
    NVA_ST_EE_WRITE = 2'b01,
    NVA_ST_FL_WRITE = 2'b10,
    NVA_ST_FL_ERASE = 2'b11
  } nva_state_e;

  typedef enum logic [1:0] {
    NVA_UL_IDLE = 2'b00,
    NVA_UL_FIRST = 2'b01,
    NVA_UL_ARMED = 2'b10
  } nva_unlock_e;

  typedef struct packed {
    logic program_data_select;
    logic config_space_select;
    logic erase_select;
    logic write_enable_bit;
    logic write_start;
  } nva_ctrl_s;

endpackage

// *** nva_top.sv ***
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "nva_defs.svh"

// Behaviour
// [RQ1] Each table read moves exactly one program memory byte into the latch.
// [RQ2] Program write commits the 32 holding latches as one aligned block.
// [RQ3] Erase clears one aligned 64-byte block; no bulk erase from code.
// [RQ4] A whole-array erase request from software is refused.
// [RQ5] Instruction fetch stalls while a program write or erase runs.
// [RQ6] An internal timer ends every program write or erase.
// [RQ7] Any value may be stored; invalid fetched words become no-ops.
// [RQ8] Program/data transfers pass one byte at a time via the table latch.
// [RQ9] A table write fills a holding latch, not the flash array.
// [RQ10] Table pointer is a byte address with no alignment demanded.
// [RQ11] EEPROM read: set address, clear select bits, set read bit.
// [RQ12] EEPROM data keeps last read until a new read or software write.
// [RQ13] Write starts only after 55h, 0AAh to unlock, then write bit.
// [RQ14] Software keeps interrupts off around the unlock sequence.
// [RQ15] Write bit cannot be set unless write enable is already set.
// [RQ16] Setting enable and write bit in one write starts nothing.
// [RQ17] Hardware never clears the write enable bit.
// [RQ18] Software keeps write enable clear outside intended updates.
// [RQ19] During a write cycle control, address and data ignore writes.
// [RQ20] At cycle end hardware clears write bit and sets complete flag.
// [RQ21] Complete flag stays set until software clears it.
// [RQ22] Software may read back and compare each written location.
// [RQ23] Software clears config select to reach the data EEPROM.
module nva_top
  import nva_pkg::*;
#(
  parameter int unsigned EE_WRITE_CYC = `NVA_EE_WRITE_US * `NVA_CLK_MHZ,
  parameter int unsigned FL_PROG_CYC = `NVA_FL_PROG_US * `NVA_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction fetch port
  input wire logic [6:0] fetch_addr,
  output logic [15:0] fetch_word,
  output logic fetch_stall,
  // Completion flag level
  output logic write_complete_flag
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [23:0] load_count(input int unsigned cyc);
    int unsigned c;
    c = (cyc < 1) ? 1 : cyc;
    return 24'(c - 1);
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  // ****************************************
  // State
  // ****************************************
  nva_state_e state_reg, state_next;
  nva_unlock_e unlock_reg, unlock_next;
  nva_ctrl_s ctrl_reg, ctrl_next;
  logic [23:0] count_reg, count_next;
  logic [7:0] ee_addr_reg;
  logic [7:0] ee_data_reg;
  logic [7:0] tbl_ptr_reg;
  logic [7:0] table_latch_reg;
  logic flag_reg, flag_next;
  logic bulk_refused_reg, bulk_refused_next;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] fetch_reg;
  logic [7:0] eeprom_mem [`NVA_EE_BYTES];
  logic [7:0] flash_mem [`NVA_FL_BYTES];
  logic [7:0] hold_mem [`NVA_HOLD_BYTES];

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_req = req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = wb_adr_i == `NVA_REG_CTRL;
  wire hit_unlock = wb_adr_i == `NVA_REG_UNLOCK;
  wire hit_addr = wb_adr_i == `NVA_REG_EE_ADDR;
  wire hit_data = wb_adr_i == `NVA_REG_EE_DATA;
  wire hit_ptr = wb_adr_i == `NVA_REG_TBL_PTR;
  wire hit_latch = wb_adr_i == `NVA_REG_TBL_LATCH;
  wire hit_cmd = wb_adr_i == `NVA_REG_TBL_CMD;
  wire hit_stat = wb_adr_i == `NVA_REG_STATUS;
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire busy = state_reg != NVA_ST_IDLE;
  wire fl_busy = busy & (state_reg != NVA_ST_EE_WRITE);
  wire done = busy & (count_reg == 24'h000000);

  // Writes to control, address and data frozen while busy
  wire wr_ctrl = wr_req & hit_ctrl & ~busy; // [RQ19]
  wire wr_addr = wr_req & hit_addr & ~busy; // [RQ19]
  wire wr_data = wr_req & hit_data & ~busy; // [RQ19]
  wire wr_ptr = wr_req & hit_ptr & ~fl_busy;
  wire wr_latch = wr_req & hit_latch & ~fl_busy;
  wire wr_cmd = wr_req & hit_cmd & ~fl_busy;
  wire wr_stat = wr_req & hit_stat;

  // Start needs old enable set and the armed unlock
  wire start = wr_ctrl & wbyte[`NVA_CTRL_WR]
    & ctrl_reg.write_enable_bit // [RQ15] [RQ16]
    & (unlock_reg == NVA_UL_ARMED) // [RQ13]
    & ~wbyte[`NVA_CTRL_CONFIG_SPACE_SELECT]; // [RQ23]
  wire rd_go = wr_ctrl & wbyte[`NVA_CTRL_RD] & ~wbyte[`NVA_CTRL_WR]
    & ~wbyte[`NVA_CTRL_PGD] & ~wbyte[`NVA_CTRL_CONFIG_SPACE_SELECT]; // [RQ11]
  wire tbl_rd = wr_cmd & wbyte[`NVA_CMD_READ]; // [RQ1] [RQ8]
  wire tbl_wr = wr_cmd & wbyte[`NVA_CMD_WRITE]; // [RQ9]
  wire bulk_req = wr_cmd & wbyte[`NVA_CMD_BULK]; // [RQ4]
  wire [7:0] ptr_inc = tbl_ptr_reg + 8'h01;
  wire [2:0] prog_blk = tbl_ptr_reg[7:5]; // [RQ2]
  wire [1:0] erase_blk = tbl_ptr_reg[7:6]; // [RQ3]

  // ****************************************
  // Unlock sequence
  // ****************************************
  // Any other bus write breaks the key sequence
  always_comb begin
    unlock_next = unlock_reg;
    if (wr_req) begin
      unlock_next = NVA_UL_IDLE; // [RQ13]
      if (hit_unlock & ~busy) begin
        if (wbyte == `NVA_KEY_FIRST) begin
          unlock_next = NVA_UL_FIRST;
        end else if (wbyte == `NVA_KEY_SECOND &&
                     unlock_reg == NVA_UL_FIRST) begin
          unlock_next = NVA_UL_ARMED;
        end
      end
    end
  end

  // ****************************************
  // Control register and sequencer
  // ****************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    state_next = state_reg;
    count_next = count_reg;
    if (wr_ctrl) begin
      ctrl_next.program_data_select = wbyte[`NVA_CTRL_PGD];
      ctrl_next.config_space_select = wbyte[`NVA_CTRL_CONFIG_SPACE_SELECT];
      ctrl_next.erase_select = wbyte[`NVA_CTRL_FREE];
      ctrl_next.write_enable_bit = wbyte[`NVA_CTRL_WRITE_ENABLE_BIT]; // [RQ17]
    end
    // The start write itself picks EEPROM, program or erase
    if (start) begin
      ctrl_next.write_start = 1'b1;
      if (!wbyte[`NVA_CTRL_PGD]) begin
        state_next = NVA_ST_EE_WRITE;
        count_next = load_count(EE_WRITE_CYC);
      end else begin
        state_next = wbyte[`NVA_CTRL_FREE] ? NVA_ST_FL_ERASE
                                           : NVA_ST_FL_WRITE;
        count_next = load_count(FL_PROG_CYC); // [RQ6]
      end
    end else if (done) begin
      ctrl_next.write_start = 1'b0; // [RQ20]
      state_next = NVA_ST_IDLE; // [RQ6]
    end else if (busy) begin
      count_next = count_reg - 24'h000001; // [RQ6]
    end
  end

  // Flag set wins over a software clear
  always_comb begin
    flag_next = done | (flag_reg & ~(wr_stat & wbyte[`NVA_STAT_DONE]));
    bulk_refused_next = bulk_req
      | (bulk_refused_reg & ~(wr_stat & wbyte[`NVA_STAT_BULK]));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= NVA_ST_IDLE;
      unlock_reg <= NVA_UL_IDLE;
      ctrl_reg <= '0;
      count_reg <= 24'h000000;
      flag_reg <= 1'b0;
      bulk_refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      unlock_reg <= unlock_next;
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      flag_reg <= flag_next; // [RQ20] [RQ21]
      bulk_refused_reg <= bulk_refused_next; // [RQ4]
    end
  end

  // ****************************************
  // EEPROM address and data
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ee_addr_reg <= 8'h00;
      ee_data_reg <= 8'h00;
    end else begin
      if (wr_addr) begin
        ee_addr_reg <= wbyte;
      end
      if (wr_data) begin
        ee_data_reg <= wbyte; // [RQ12]
      end else if (rd_go) begin
        ee_data_reg <= eeprom_mem[ee_addr_reg]; // [RQ11] [RQ12]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (done && state_reg == NVA_ST_EE_WRITE) begin
      eeprom_mem[ee_addr_reg] <= ee_data_reg;
    end
  end

  // ****************************************
  // Table pointer and latch
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_ptr_reg <= 8'h00;
      table_latch_reg <= 8'h00;
    end else begin
      if (wr_ptr) begin
        tbl_ptr_reg <= wbyte; // [RQ10]
      end else if (wr_cmd & wbyte[`NVA_CMD_INC]) begin
        tbl_ptr_reg <= ptr_inc; // [RQ10]
      end
      // Table read takes the pointer before its increment
      if (wr_latch) begin
        table_latch_reg <= wbyte;
      end else if (tbl_rd) begin
        table_latch_reg <= flash_mem[tbl_ptr_reg]; // [RQ1] [RQ8]
      end
    end
  end

  // ****************************************
  // Holding latches
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `NVA_HOLD_BYTES; i++) begin
        hold_mem[i] <= `NVA_ERASED;
      end
    end else if (done && state_reg == NVA_ST_FL_WRITE) begin
      // Latches return to erased after a commit
      for (int i = 0; i < `NVA_HOLD_BYTES; i++) begin
        hold_mem[i] <= `NVA_ERASED;
      end
    end else if (tbl_wr) begin
      hold_mem[tbl_ptr_reg[4:0]] <= table_latch_reg; // [RQ9] [RQ8]
    end
  end

  // ****************************************
  // Flash array
  // ****************************************
  always_ff @(posedge clk) begin
    if (done && state_reg == NVA_ST_FL_WRITE) begin
      for (int i = 0; i < `NVA_HOLD_BYTES; i++) begin
        flash_mem[{prog_blk, 5'(i)}] <= hold_mem[i]; // [RQ2] [RQ7]
      end
    end else if (done && state_reg == NVA_ST_FL_ERASE) begin
      for (int i = 0; i < `NVA_ERASE_BYTES; i++) begin
        flash_mem[{erase_blk, 6'(i)}] <= `NVA_ERASED; // [RQ3]
      end
    end
  end

  // Fetch holds its last word while flash is busy
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_reg <= 16'h0000;
    end else if (!fl_busy) begin
      fetch_reg <= {flash_mem[{fetch_addr, 1'b1}],
                    flash_mem[{fetch_addr, 1'b0}]}; // [RQ7]
    end
  end

  assign fetch_stall = fl_busy; // [RQ5]
  assign fetch_word = fetch_reg;
  assign write_complete_flag = flag_reg;

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  logic [7:0] ctrl_byte;
  logic [7:0] stat_byte;
  logic [31:0] rd_val;

  assign ctrl_byte = {ctrl_reg.program_data_select,
                      ctrl_reg.config_space_select, 1'b0,
                      ctrl_reg.erase_select, 1'b0,
                      ctrl_reg.write_enable_bit,
                      ctrl_reg.write_start, 1'b0};
  assign stat_byte = {4'h0, busy & ~fl_busy, fl_busy,
                      bulk_refused_reg, flag_reg};

  // Write-only registers read back as zero
  always_comb begin
    case (wb_adr_i)
      `NVA_REG_CTRL: rd_val = byte_word(ctrl_byte);
      `NVA_REG_EE_ADDR: rd_val = byte_word(ee_addr_reg);
      `NVA_REG_EE_DATA: rd_val = byte_word(ee_data_reg);
      `NVA_REG_TBL_PTR: rd_val = byte_word(tbl_ptr_reg);
      `NVA_REG_TBL_LATCH: rd_val = byte_word(table_latch_reg);
      `NVA_REG_STATUS: rd_val = byte_word(stat_byte);
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      // Ack drops one cycle after it rises
      ack_reg <= req;
      if (req) begin
        dat_reg <= rd_val;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule

// *** nva_top_asserts.sv ***
`timescale 1ns/1ns
`include "nva_defs.svh"
module nva_top_asserts #(
  parameter int unsigned EE_WRITE_CYC = 20,
  parameter int unsigned FL_PROG_CYC = 30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Fetch and flag
  input wire logic [15:0] fetch_word,
  input wire logic fetch_stall,
  input wire logic write_complete_flag
);
  // ****************************************
  // Helpers
  // ****************************************
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire clr = req && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
    && wb_adr_i == `NVA_REG_STATUS;
  wire unmapped = wb_adr_i[1:0] != 2'h0 || wb_adr_i > `NVA_REG_STATUS;
  int stall_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst || !fetch_stall) stall_cnt_reg <= 0;
    else stall_cnt_reg <= stall_cnt_reg + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Checks
  // ****************************************
  AST_ACK_ONE: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_NO_ACK: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_UNMAPPED: assert property (req && !wb_we_i && unmapped
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_FLAG_HOLD: assert property (
    write_complete_flag && !clr && !$past(clr) |=> write_complete_flag)
    else $error("flag dropped without clear");
  AST_STALL_FLAG: assert property (
    $fell(fetch_stall) |-> ##[0:1] write_complete_flag)
    else $error("flag not set at end of operation");
  AST_STALL_LEN: assert property (
    $fell(fetch_stall) |-> stall_cnt_reg == FL_PROG_CYC)
    else $error("program timer length wrong");
  AST_FETCH_HOLD: assert property (
    fetch_stall && $past(fetch_stall) |-> $stable(fetch_word))
    else $error("fetch advanced while stalled");
  cover property ($rose(write_complete_flag));
  cover property ($rose(fetch_stall));
  cover property (req && !wb_we_i && unmapped);
endmodule

bind nva_top nva_top_asserts #(
  .EE_WRITE_CYC(EE_WRITE_CYC),
  .FL_PROG_CYC(FL_PROG_CYC)
) i_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fetch_word(fetch_word), .fetch_stall(fetch_stall),
  .write_complete_flag(write_complete_flag)
);

// *** nva_core_model.sv ***
`timescale 1ns/1ns
module nva_core_model (
  // Clock and answer
  input wire logic clk,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Request
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // One whole transfer, nothing interleaved
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~{24'h0, d};
    @(posedge clk);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
`include "nva_defs.svh"
module tb;
  localparam logic [7:0] CT = `NVA_REG_CTRL;
  localparam logic [7:0] UL = `NVA_REG_UNLOCK;
  localparam logic [7:0] EA = `NVA_REG_EE_ADDR;
  localparam logic [7:0] ED = `NVA_REG_EE_DATA;
  localparam logic [7:0] TP = `NVA_REG_TBL_PTR;
  localparam logic [7:0] TL = `NVA_REG_TBL_LATCH;
  localparam logic [7:0] TC = `NVA_REG_TBL_CMD;
  localparam logic [7:0] ST = `NVA_REG_STATUS;
  logic clk, rst, cyc, stb, we, ack, stall, flag;
  logic [7:0] adr, q, a, d;
  logic [3:0] sel;
  logic [31:0] dw, dr, seed;
  logic [6:0] fa;
  logic [15:0] fw;
  logic [7:0] img [33];
  int failures, n_checks, i, j;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  nva_top #(.EE_WRITE_CYC(20), .FL_PROG_CYC(30)) i_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .fetch_addr(fa), .fetch_word(fw),
    .fetch_stall(stall), .write_complete_flag(flag));
  nva_core_model i_core (.clk(clk), .wb_dat_o(dr), .wb_ack_o(ack),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] v);
    i_core.xfer(1'b1, ad, v, q);
  endtask
  task automatic rd(string n, logic [7:0] ad, logic [7:0] e);
    i_core.xfer(1'b0, ad, 8'h00, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask
  // Config select kept clear, enable from c left set after the update
  task automatic go(logic [7:0] c);
    wr(CT, c);
    wr(UL, `NVA_KEY_FIRST);
    wr(UL, `NVA_KEY_SECOND);
    wr(CT, c | 8'h02);
  endtask
  task automatic done();
    for (i = 0; i < 200 && flag !== 1'b1; i++) @(posedge clk);
    chk("flag", {15'h0, flag}, 16'h1);
    wr(ST, 8'h01);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    seed = 48;
    fa = 7'h00;
    failures = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("ctrl", CT, 8'h00);
    rd("unmapped", 8'h03, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    for (j = 0; j < 3; j++) begin
      a = rnd();
      d = rnd();
      wr(EA, a);
      wr(ED, d);
      go(8'h04);
      rd("busy", ST, 8'h08);
      wr(ED, ~d);
      wr(CT, 8'h00);
      done();
      rd("ctrl", CT, 8'h04);
      wr(ED, 8'h00);
      wr(CT, 8'h01);
      rd("eeprom_data_reg", ED, d);
      rd("eehold", ED, d);
    end
    go(8'h00);
    rd("nostart", ST, 8'h00);
    wr(UL, `NVA_KEY_FIRST);
    wr(UL, `NVA_KEY_SECOND);
    wr(CT, 8'h06);
    rd("both", ST, 8'h00);
    rd("both_ctrl", CT, 8'h04);
    wr(UL, `NVA_KEY_FIRST);
    wr(EA, a);
    wr(UL, `NVA_KEY_SECOND);
    wr(CT, 8'h06);
    rd("nostart", ST, 8'h00);
    wr(TC, 8'h04);
    rd("bulk", ST, 8'h02);
    wr(ST, 8'h02);
    wr(TP, 8'h40);
    go(8'h94);
    chk("stall", {15'h0, stall}, 16'h1);
    done();
    wr(TP, 8'h40);
    for (j = 0; j < 32; j++) begin
      img[j] = rnd();
      wr(TL, img[j]);
      wr(TC, 8'h0A);
    end
    img[32] = `NVA_ERASED;
    wr(TP, 8'h45);
    wr(TC, 8'h01);
    rd("hold", TL, `NVA_ERASED);
    go(8'h84);
    done();
    wr(TP, 8'h41);
    for (j = 1; j < 33; j++) begin
      wr(TC, 8'h09);
      rd("table_read_op", TL, img[j]);
    end
    for (j = 0; j < 6; j++) begin
      i = rnd() % 16;
      fa <= 7'h20 + 7'(i);
      repeat (2) @(posedge clk);
      chk("fetch", fw, {img[2 * i + 1], img[2 * i]});
    end
    tally_and_finish();
  end
endmodule
